/* File: rtl/evf_base_reg.sv */
/*
  Vector base offset register with region check.
  Assumes writes come from core logic on clock_in.
*/
`include "evf_map.svh"

module evf_base_reg
  import evf_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire logic [31:0] wr_data_in,
  output logic [31:0] base_out,
  output logic wr_err_out
);

  logic [31:0] base_r;
  logic [31:0] masked;

  function automatic logic base_legal(input logic [31:0] a);
    return a <= `EVF_SRAM_TOP;
  endfunction

  assign masked = wr_data_in & `EVF_BASE_MASK;

  // ==========================================================
  // Base register
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      base_r <= `EVF_BASE_RESET;
    end else if (wr_en_in && base_legal(masked)) begin
      base_r <= masked;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wr_err_out <= 1'b0;
    end else begin
      wr_err_out <= wr_en_in && !base_legal(masked);
    end
  end

  assign base_out = base_r;

  a_base_in_region: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    base_r <= `EVF_SRAM_TOP) else $error("Vector base outside code or SRAM region");

endmodule

/* File: rtl/evf_fetch.sv */
/*
  Exception vector fetch unit: reads stack pointer and reset handler after
  reset, then the handler word of each exception taken in idle with a valid number.
  Assumes a memory port that answers one read per request with rd_valid_in,
  one or more cycles later, and holds no other reader.
*/
`include "evf_map.svh"

module evf_fetch
  import evf_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic base_wr_in,
  input wire logic [31:0] base_wdata_in,
  output logic [31:0] base_rdata_out,
  output logic base_err_out,
  input wire logic exc_req_in,
  input wire logic [8:0] exc_num_in,
  output logic exc_ack_out,
  output logic exc_bad_out,
  output logic [31:0] mem_addr_out,
  output logic mem_rd_out,
  input wire logic mem_rd_valid_in,
  input wire logic [31:0] mem_rd_data_in,
  output evf_vec_t vec_out,
  output logic [8:0] vec_num_out,
  output logic vec_valid_out,
  output logic boot_done_out
);

  evf_state_t state_r;
  evf_req_t req_r;
  logic boot_sp_r;
  logic [31:0] base;
  logic [31:0] addr_nxt;
  logic take;
  logic rd_pend_r;

  // ==========================================================
  // Numbering and addressing
  function automatic logic num_valid(input logic [8:0] n);
    logic ok;
    ok = 1'b0;
    unique case (n)
      `EVF_EXC_RESET, `EVF_EXC_NMI, `EVF_EXC_HARD, `EVF_EXC_MEM, `EVF_EXC_BUS,
      `EVF_EXC_USAGE, `EVF_EXC_SVC, `EVF_EXC_DBGMON, `EVF_EXC_PENDABLE_SERVICE_EXCEPTION,
      `EVF_EXC_TICK: ok = 1'b1;
      default: ok = (n >= `EVF_EXC_EXT0) && (n <= `EVF_EXT_MAX);
    endcase
    return ok;
  endfunction

  function automatic logic [31:0] word_addr(input logic [31:0] b, input logic [8:0] n);
    return b + {21'h00_0000, n, 2'b00};
  endfunction

  evf_base_reg u_base (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(base_wr_in),
    .wr_data_in(base_wdata_in),
    .base_out(base),
    .wr_err_out(base_err_out)
  );

  assign base_rdata_out = base;

  assign take = (state_r == EVF_IDLE) && exc_req_in;
  assign exc_ack_out = take;
  assign exc_bad_out = take && !num_valid(exc_num_in);

  // ==========================================================
  // Sequencer
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_r <= EVF_BOOT;
      boot_sp_r <= 1'b1;
    end else begin
      unique case (state_r)
        EVF_BOOT: begin
          if (mem_rd_valid_in) begin
            if (boot_sp_r) begin
              boot_sp_r <= 1'b0;
            end else begin
              state_r <= EVF_IDLE;
            end
          end
        end
        EVF_IDLE: begin
          if (take && num_valid(exc_num_in)) begin
            state_r <= EVF_FETCH;
          end
        end
        EVF_FETCH: begin
          if (mem_rd_valid_in) begin
            state_r <= EVF_IDLE;
          end
        end
        default: begin
          state_r <= EVF_IDLE;
        end
      endcase
    end
  end

  // Base latched at entry so a later write cannot move a fetch in flight
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      req_r <= '0;
    end else if (take) begin
      req_r <= '{number: exc_num_in, base: base};
    end
  end

  // ==========================================================
  // Memory request
  // One read outstanding; no new strobe until its answer arrives
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= (rd_pend_r || mem_rd_out) && !mem_rd_valid_in;
    end
  end

  always_comb begin
    addr_nxt = word_addr(req_r.base, req_r.number);
    if (state_r == EVF_BOOT) begin
      addr_nxt = boot_sp_r ? word_addr(base, `EVF_SP_WORD) : base + `EVF_PC_BYTE;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      mem_rd_out <= 1'b0;
      mem_addr_out <= 32'h0000_0000;
    end else begin
      mem_rd_out <= ((state_r == EVF_BOOT) || (state_r == EVF_FETCH)) && !mem_rd_valid_in && !mem_rd_out && !rd_pend_r;
      mem_addr_out <= addr_nxt;
    end
  end

  // ==========================================================
  // Answers
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      vec_out <= '0;
      vec_num_out <= 9'h000;
      vec_valid_out <= 1'b0;
      boot_done_out <= 1'b0;
    end else begin
      vec_valid_out <= 1'b0;
      if (mem_rd_valid_in && state_r == EVF_BOOT && boot_sp_r) begin
        vec_out.stack_ptr <= mem_rd_data_in;
      end else if (mem_rd_valid_in && state_r == EVF_BOOT) begin
        vec_out.handler <= mem_rd_data_in;
        vec_num_out <= `EVF_EXC_RESET;
        vec_valid_out <= 1'b1;
        boot_done_out <= 1'b1;
      end else if (mem_rd_valid_in && state_r == EVF_FETCH) begin
        vec_out.handler <= mem_rd_data_in;
        vec_num_out <= req_r.number;
        vec_valid_out <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Checks
  a_boot_sp_addr: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (mem_rd_out && state_r == EVF_BOOT && boot_sp_r) |-> mem_addr_out == base)
    else $error("Boot stack read not at table word zero");

  a_boot_pc_addr: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (mem_rd_out && state_r == EVF_BOOT && !boot_sp_r) |-> mem_addr_out == base + `EVF_PC_BYTE)
    else $error("Boot handler read not at offset four");

  a_reset_base_code: assert property (@(posedge clock_in)
    $fell(sys_rst_in) |-> base <= `EVF_CODE_TOP)
    else $error("Base not in code region after reset");

  a_fetch_addr: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (mem_rd_out && state_r == EVF_FETCH) |-> mem_addr_out == req_r.base + {21'h00_0000, req_r.number, 2'b00})
    else $error("Handler read not at number word");

  a_base_frozen: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (state_r == EVF_FETCH) |=> $stable(req_r) || $past(state_r) != EVF_FETCH)
    else $error("Latched base changed during fetch");

  a_base_next: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    take |=> req_r.base == $past(base))
    else $error("Entry did not take current base");

  a_reserved_refused: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (take && (exc_num_in inside {9'h000, 9'h007, 9'h008, 9'h009, 9'h00A, 9'h00D}))
    |-> exc_bad_out ##1 state_r == EVF_IDLE)
    else $error("Reserved number accepted");

  a_vec_number: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (mem_rd_valid_in && state_r == EVF_FETCH)
    |=> vec_valid_out && vec_num_out == req_r.number && vec_out.handler == $past(mem_rd_data_in))
    else $error("Handler answer wrong");

  a_boot_order: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (vec_valid_out && vec_num_out == `EVF_EXC_RESET) |-> boot_done_out && !boot_sp_r)
    else $error("Reset handler before stack pointer");

  a_base_readback: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (base_wr_in && !base_err_out && ((base_wdata_in & `EVF_BASE_MASK) <= `EVF_SRAM_TOP))
    |=> base_rdata_out == ($past(base_wdata_in) & `EVF_BASE_MASK))
    else $error("Base write not readable");

  a_single_read: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (mem_rd_out || (rd_pend_r && !mem_rd_valid_in)) |=> !mem_rd_out)
    else $error("Second read issued before answer");

endmodule

/* File: rtl/evf_map.svh */
/*
  Offsets, region bounds and reset values of the exception vector fetch unit.
  Assumes inclusion by bare name from rtl/.
*/
`ifndef EVF_MAP_SVH
`define EVF_MAP_SVH

// ==========================================================
// Exception numbers
`define EVF_EXC_RESET 9'h001
`define EVF_EXC_NMI 9'h002
`define EVF_EXC_HARD 9'h003
`define EVF_EXC_MEM 9'h004
`define EVF_EXC_BUS 9'h005
`define EVF_EXC_USAGE 9'h006
`define EVF_EXC_SVC 9'h00B
`define EVF_EXC_DBGMON 9'h00C
`define EVF_EXC_PENDABLE_SERVICE_EXCEPTION 9'h00E
`define EVF_EXC_TICK 9'h00F
`define EVF_EXC_EXT0 9'h010
`define EVF_EXT_MAX 9'h1EF

// ==========================================================
// Table offsets and base handling
`define EVF_SP_WORD 9'h000
`define EVF_PC_BYTE 32'h0000_0004
`define EVF_BASE_RESET 32'h0000_0000
`define EVF_BASE_MASK 32'h3FFF_FF80
`define EVF_CODE_TOP 32'h1FFF_FFFF
`define EVF_SRAM_TOP 32'h3FFF_FFFF

`endif

/* File: rtl/evf_pkg.sv */
/*
  Types of the exception vector fetch unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package evf_pkg;

  // ==========================================================
  // Fetch request and answer carriers
  typedef struct packed {
    logic [8:0] number;
    logic [31:0] base;
  } evf_req_t;

  typedef struct packed {
    logic [31:0] stack_ptr;
    logic [31:0] handler;
  } evf_vec_t;

  typedef enum logic [1:0] {
    EVF_BOOT,
    EVF_IDLE,
    EVF_FETCH
  } evf_state_t;

endpackage

/* File: sim/evf_mem_model.sv */
/*
  Instruction memory model holding the vector table.
  Assumes one read outstanding at a time, strobed by the fetch unit.
*/
module evf_mem_model (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic slow_in,
  input wire logic rd_in,
  input wire logic [31:0] addr_in,
  output logic rd_valid_out,
  output logic [31:0] rd_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] addr_r;
  logic [3:0] wait_r;
  // ==========================================================
  // Table word is the inverse of its byte address
  always_ff @(posedge clock_in) begin
    rd_valid_out <= 1'b0;
    rd_data_out <= ~rd_data_out;
    if (sys_rst_in) begin
      wait_r <= 4'h0;
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
      if (wait_r == 4'h1) begin
        rd_valid_out <= 1'b1;
        rd_data_out <= ~addr_r;
      end
    end else if (rd_in) begin
      addr_r <= addr_in;
      wait_r <= slow_in ? 4'h6 : 4'h1;
    end
  end
endmodule

/* File: sim/tb_top.sv */
/*
  Testbench of the exception vector fetch unit.
  Assumes evf_fetch and the memory model from sim/.
*/
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  import evf_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, wr = 0, req = 0, slow = 0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [8:0] num = 9'h000;
  logic [31:0] base, maddr, mdata;
  logic berr, ack, bad, mrd, mvalid, vvalid, bdone;
  logic [8:0] vnum;
  evf_vec_t vec;
  int fails = 0, checks = 0, cyc = 0;
  evf_fetch evf_fetch_inst (.clock_in(clk), .sys_rst_in(rst), .base_wr_in(wr), .base_wdata_in(wdata),
    .base_rdata_out(base), .base_err_out(berr), .exc_req_in(req), .exc_num_in(num),
    .exc_ack_out(ack), .exc_bad_out(bad), .mem_addr_out(maddr), .mem_rd_out(mrd),
    .mem_rd_valid_in(mvalid), .mem_rd_data_in(mdata), .vec_out(vec), .vec_num_out(vnum),
    .vec_valid_out(vvalid), .boot_done_out(bdone));
  evf_mem_model evf_mem_model_inst (.clock_in(clk), .sys_rst_in(rst), .slow_in(slow), .rd_in(mrd),
    .addr_in(maddr), .rd_valid_out(mvalid), .rd_data_out(mdata));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  task end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task run_exc(input logic [8:0] n, input logic [31:0] b, input logic rej);
    int i;
    @(posedge clk);
    req <= 1'b1;
    num <= n;
    #1;
    i = 0;
    while (ack !== 1'b1 && i < 50) begin @(posedge clk); #1; i++; end
    `CHK(bad, rej);
    @(posedge clk);
    req <= 1'b0;
    i = 0;
    while (vvalid !== 1'b1 && i < 20) begin @(posedge clk); #1; i++; end
    if (rej) `CHK(vvalid, 1'b0)
    else begin
      `CHK(vec.handler, ~(b + {21'h00_0000, n, 2'b00}));
      `CHK(vnum, n);
    end
  endtask
  task set_base(input logic [31:0] w, input logic [31:0] e);
    @(posedge clk);
    wr <= 1'b1;
    wdata <= w;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    `CHK(base, e);
    `CHK(berr, 1'b0);
  endtask
  task t_boot;
    int i;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK(base, 32'h0000_0000);
    i = 0;
    while (bdone !== 1'b1 && i < 40) begin @(posedge clk); #1; i++; end
    `CHK(vec.stack_ptr, 32'hFFFF_FFFF);
    `CHK(vec.handler, ~32'h0000_0004);
    `CHK(vnum, 9'h001);
    $display("boot done");
  endtask
  task t_numbers;
    static logic [8:0] ok[12] = '{9'h002, 9'h003, 9'h004, 9'h005, 9'h006, 9'h00B, 9'h00C, 9'h00E,
      9'h00F, 9'h010, 9'h011, 9'h1EF};
    static logic [8:0] rsv[7] = '{9'h000, 9'h007, 9'h008, 9'h009, 9'h00A, 9'h00D, 9'h1F0};
    foreach (ok[k]) run_exc(ok[k], 32'h0000_0000, 1'b0);
    foreach (rsv[k]) run_exc(rsv[k], 32'h0000_0000, 1'b1);
    $display("numbers done");
  endtask
  task t_base;
    set_base(32'hC000_00FF, 32'h0000_0080);
    run_exc(9'h00F, 32'h0000_0080, 1'b0);
    set_base(32'h2000_0100, 32'h2000_0100);
    slow <= 1'b1;
    fork
      run_exc(9'h010, 32'h2000_0100, 1'b0);
      begin repeat (4) @(posedge clk); wr <= 1'b1; wdata <= 32'h2000_0200; @(posedge clk); wr <= 1'b0; end
    join
    run_exc(9'h010, 32'h2000_0200, 1'b0);
    $display("base done");
  endtask
  // ==========================================================
  // Main sequence and timeout
  initial begin
    t_boot();
    t_numbers();
    t_base();
    end_sim();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
endmodule
